//--- logic/mrs_framer.sv
// Functional notes
// - bit rate 2400 to 38400 selectable
// - half duplex, release pair after reply
// - transmit only in reply to query
// - broadcast executed, no reply sent
// - normal reply echoes function plus data
// - error reply: altered function, cause byte
// - binary framing only, no text mode
// - start, 8 data LSB first, parity, stop
// - reply characters sent without gaps
// - 3.5 character silence before message
// - 3.5 character silence ends message
// - 1.5 character gap flushes partial frame
// - early characters appended to message
// - address, function, data, 16-bit check
// - act only on own address or broadcast
// - reply carries own station address
// - address zero is broadcast
// - receiver listens continuously
// - read query carries start and count
// - check value verified before acting
// - shared rate and parity settings
// - check value low byte first
// - error function has top bit set
// - only functions 03, 06, 10 supported
// - parity or check error: silently dropped
`timescale 1ns/1ps
`default_nettype none
module mrs_framer #(
	parameter int BUF_DEPTH = 16
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic rx_in,
	output logic tx_out,
	output logic tx_oe_n,
	input wire logic [2:0] baud_sel,
	input wire logic parity_en,
	input wire logic parity_odd,
	input wire logic [7:0] station_addr,
	output logic cmd_valid,
	output logic [7:0] cmd_func,
	output logic cmd_bcast,
	output logic [7:0] cmd_len,
	input wire logic [7:0] app_idx,
	output logic [7:0] app_data,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_exc,
	input wire logic [7:0] rsp_len,
	input wire logic [7:0] rsp_byte,
	output logic [7:0] rsp_idx,
	output logic frame_drop
);
	localparam int IW = $clog2(BUF_DEPTH);

	typedef struct packed {
		mrs_pkg::mrs_fr_st_t st;
		logic [BUF_DEPTH-1:0][7:0] rbuf;
		logic [7:0] cnt;
		logic [15:0] crc;
		logic bad;
		logic g15;
		logic [7:0] func;
		logic [7:0] exc;
		logic bcast;
		logic [7:0] nlen;
		logic [7:0] pos;
		logic [10:0] tx_sh;
		logic [3:0] tx_bits;
		logic [11:0] tdiv;
		logic tph;
		logic tx_out;
		logic tx_oe_n;
		logic cmd_valid;
		logic [7:0] cmd_func;
		logic cmd_bcast;
		logic [7:0] cmd_len;
		logic [7:0] app_data;
		logic [7:0] rsp_idx;
		logic frame_drop;
	} mrs_fr_t;

	mrs_fr_t s;
	mrs_fr_t next_s;
	logic [11:0] half_div;
	logic rx_valid;
	logic [7:0] rx_data;
	logic rx_perr;
	logic gap15;
	logic gap35;
	logic tx_tick;
	logic btick;
	logic [7:0] b;
	logic [8:0] last;
	logic [7:0] dptr;
	logic bc;
	logic mine;
	logic good;
	logic fc_ok;

	assign half_div = mrs_pkg::mrs_half_div(baud_sel);
	assign tx_tick = (s.tdiv == 12'(half_div - 12'h001));
	assign btick = tx_tick && s.tph;

	mrs_uart_rx u_rx (
		.sys_clk(sys_clk),
		.rst(rst),
		.rx_in(rx_in),
		.half_div(half_div),
		.parity_en(parity_en),
		.parity_odd(parity_odd),
		.byte_valid(rx_valid),
		.byte_data(rx_data),
		.byte_perr(rx_perr),
		.gap15(gap15),
		.gap35(gap35)
	);

	// ----------------------------------------
	// framing, decode and reply
	// ----------------------------------------
	always_comb begin
		next_s = s;
		next_s.cmd_valid = 1'b0;
		next_s.frame_drop = 1'b0;
		next_s.tdiv = tx_tick ? 12'h000 : 12'(s.tdiv + 12'h001);
		if (tx_tick) begin
			next_s.tph = ~s.tph;
		end
		dptr = 8'(app_idx + mrs_pkg::HDR_BYTES);
		next_s.app_data = (dptr < 8'(BUF_DEPTH)) ? s.rbuf[dptr[IW-1:0]] : 8'h00;
		bc = (s.rbuf[0] == mrs_pkg::BCAST_ADDR);
		mine = (s.rbuf[0] == station_addr) && (station_addr != mrs_pkg::BCAST_ADDR)
			&& (station_addr <= mrs_pkg::MAX_ADDR);
		// the crc over a whole frame, check bytes included, leaves zero
		good = !s.bad && (s.cnt >= mrs_pkg::MIN_FRAME) && (s.crc == 16'h0000);
		fc_ok = (s.rbuf[1] == mrs_pkg::FC_READ_HOLD) || (s.rbuf[1] == mrs_pkg::FC_WRITE_ONE)
			|| (s.rbuf[1] == mrs_pkg::FC_WRITE_MANY);
		last = 9'(s.nlen) + 9'h004;
		if (s.pos == 8'h00) begin
			b = station_addr;
		end else if (s.pos == 8'h01) begin
			b = (s.exc != 8'h00) ? (s.func | mrs_pkg::EXC_FLAG) : s.func;
		end else if (9'(s.pos) < 9'(s.nlen) + 9'h002) begin
			b = (s.exc != 8'h00) ? s.exc : rsp_byte;
		end else if (9'(s.pos) == 9'(s.nlen) + 9'h002) begin
			b = s.crc[7:0];
		end else begin
			b = s.crc[15:8];
		end
		unique case (s.st)
			mrs_pkg::FR_HUNT: begin
				// nothing is taken until the line has been quiet long enough
				if (gap35) begin
					next_s.st = mrs_pkg::FR_RECV;
					next_s.cnt = 8'h00;
					next_s.crc = mrs_pkg::CRC_INIT;
					next_s.bad = 1'b0;
					next_s.g15 = 1'b0;
				end
			end
			mrs_pkg::FR_RECV: begin
				if (rx_valid) begin
					if (s.cnt != 8'h00 && s.g15) begin
						next_s.rbuf[0] = rx_data;
						next_s.cnt = 8'h01;
						next_s.crc = mrs_pkg::mrs_crc_byte(mrs_pkg::CRC_INIT, rx_data);
						next_s.bad = rx_perr;
						next_s.g15 = 1'b0;
					end else begin
						// a short gap just keeps appending, so a merged frame fails its crc
						if (s.cnt < 8'(BUF_DEPTH)) begin
							next_s.rbuf[s.cnt[IW-1:0]] = rx_data;
						end else begin
							next_s.bad = 1'b1;
						end
						if (s.cnt != 8'hff) begin
							next_s.cnt = 8'(s.cnt + 8'h01);
						end
						next_s.crc = mrs_pkg::mrs_crc_byte(s.crc, rx_data);
						next_s.bad = next_s.bad | rx_perr | s.bad;
					end
				end else if (s.cnt != 8'h00 && gap35) begin
					next_s.st = mrs_pkg::FR_CHECK;
				end else if (s.cnt != 8'h00 && gap15) begin
					next_s.g15 = 1'b1;
				end
			end
			mrs_pkg::FR_CHECK: begin
				next_s.st = mrs_pkg::FR_HUNT;
				next_s.func = s.rbuf[1];
				next_s.bcast = bc;
				if (!good) begin
					next_s.frame_drop = 1'b1;
				end else if (bc || mine) begin
					if (fc_ok) begin
						next_s.cmd_valid = 1'b1;
						next_s.cmd_func = s.rbuf[1];
						next_s.cmd_bcast = bc;
						next_s.cmd_len = 8'(s.cnt - mrs_pkg::MIN_FRAME);
						next_s.st = mrs_pkg::FR_WAIT;
					end else if (!bc) begin
						next_s.exc = mrs_pkg::EXC_ILL_FUNC;
						next_s.nlen = 8'h01;
						next_s.st = mrs_pkg::FR_SEND;
						next_s.pos = 8'h00;
						next_s.tx_bits = 4'h0;
						next_s.crc = mrs_pkg::CRC_INIT;
						next_s.tx_oe_n = 1'b0;
					end
				end
			end
			mrs_pkg::FR_WAIT: begin
				if (rsp_valid) begin
					if (s.bcast) begin
						next_s.st = mrs_pkg::FR_HUNT;
					end else begin
						next_s.exc = rsp_exc;
						next_s.nlen = (rsp_exc != 8'h00) ? 8'h01
							: ((rsp_len > mrs_pkg::MAX_RSP_DATA) ? mrs_pkg::MAX_RSP_DATA : rsp_len);
						next_s.rsp_idx = 8'h00;
						next_s.st = mrs_pkg::FR_SEND;
						next_s.pos = 8'h00;
						next_s.tx_bits = 4'h0;
						next_s.crc = mrs_pkg::CRC_INIT;
						next_s.tx_oe_n = 1'b0;
					end
				end
			end
			mrs_pkg::FR_SEND: begin
				if (s.tx_bits == 4'h0 || (btick && s.tx_bits == 4'h1)) begin
					if (9'(s.pos) == last) begin
						// let go of the pair only once the last stop bit is out
						next_s.st = mrs_pkg::FR_HUNT;
						next_s.tx_oe_n = 1'b1;
						next_s.tx_out = 1'b1;
						next_s.tx_bits = 4'h0;
					end else begin
						// next character follows the last stop bit directly
						next_s.tx_sh = {1'b1, parity_en ? mrs_pkg::mrs_par(b, parity_odd) : 1'b1,
							b, 1'b0};
						next_s.tx_out = 1'b0;
						next_s.tx_bits = mrs_pkg::TX_FRAME_BITS;
						next_s.tdiv = 12'h000;
						next_s.tph = 1'b0;
						next_s.pos = 8'(s.pos + 8'h01);
						if (9'(s.pos) < 9'(s.nlen) + 9'h002) begin
							next_s.crc = mrs_pkg::mrs_crc_byte(s.crc, b);
						end
						if (s.pos >= 8'h02 && 9'(s.pos) < 9'(s.nlen) + 9'h002) begin
							next_s.rsp_idx = 8'(s.rsp_idx + 8'h01);
						end
					end
				end else if (btick) begin
					next_s.tx_sh = {1'b1, s.tx_sh[10:1]};
					next_s.tx_out = s.tx_sh[1];
					next_s.tx_bits = 4'(s.tx_bits - 4'h1);
				end
			end
			default: begin
				next_s.st = mrs_pkg::FR_HUNT;
				next_s.tx_oe_n = 1'b1;
				next_s.tx_out = 1'b1;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s <= '0;
			s.tx_out <= 1'b1;
			s.tx_oe_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign tx_out = s.tx_out;
	assign tx_oe_n = s.tx_oe_n;
	assign cmd_valid = s.cmd_valid;
	assign cmd_func = s.cmd_func;
	assign cmd_bcast = s.cmd_bcast;
	assign cmd_len = s.cmd_len;
	assign app_data = s.app_data;
	assign rsp_idx = s.rsp_idx;
	assign frame_drop = s.frame_drop;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_last_bit;
		s.st == mrs_pkg::FR_SEND && btick && s.tx_bits == 4'h1 && 9'(s.pos) != last;
	endsequence
	sequence s_loaded(logic [7:0] p);
		s.st == mrs_pkg::FR_SEND && s.pos == p && s.tx_bits == mrs_pkg::TX_FRAME_BITS;
	endsequence

	property p_drive_only_send;
		!tx_oe_n |-> s.st == mrs_pkg::FR_SEND;
	endproperty
	a_drive_only_send: assert property (p_drive_only_send) else $error("pair driven outside reply");
	property p_idle_high;
		tx_oe_n |-> tx_out;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("released line not idle high");
	property p_bcast_silent;
		s.st == mrs_pkg::FR_WAIT && s.bcast && rsp_valid |=> s.st == mrs_pkg::FR_HUNT ##0 tx_oe_n [*8];
	endproperty
	a_bcast_silent: assert property (p_bcast_silent) else $error("reply to broadcast");
	property p_own_addr;
		s_loaded(8'h01) |-> s.tx_sh[8:1] == station_addr;
	endproperty
	a_own_addr: assert property (p_own_addr) else $error("reply address wrong");
	property p_exc_func;
		s_loaded(8'h02) ##0 s.exc != 8'h00 |-> s.tx_sh[8:1] == (s.func | mrs_pkg::EXC_FLAG);
	endproperty
	a_exc_func: assert property (p_exc_func) else $error("error function not flagged");
	property p_crc_low_first;
		s_loaded(8'(s.nlen + 8'h03)) |-> s.tx_sh[8:1] == s.crc[7:0];
	endproperty
	a_crc_low_first: assert property (p_crc_low_first) else $error("check low byte wrong");
	property p_no_gap;
		s_last_bit |=> s.tx_bits == mrs_pkg::TX_FRAME_BITS && !tx_out && !tx_oe_n;
	endproperty
	a_no_gap: assert property (p_no_gap) else $error("gap between characters");
	property p_char_shape;
		s.st == mrs_pkg::FR_SEND && s.tx_bits == mrs_pkg::TX_FRAME_BITS |-> !s.tx_sh[0] && s.tx_sh[10]
			&& (parity_en ? s.tx_sh[9] == mrs_pkg::mrs_par(s.tx_sh[8:1], parity_odd) : s.tx_sh[9]);
	endproperty
	a_char_shape: assert property (p_char_shape) else $error("character framing wrong");
	property p_flush;
		s.st == mrs_pkg::FR_RECV && rx_valid && s.cnt != 8'h00 && s.g15 |=> s.cnt == 8'h01;
	endproperty
	a_flush: assert property (p_flush) else $error("partial frame not flushed");
	property p_drop_silent;
		s.st == mrs_pkg::FR_CHECK && (s.bad || s.crc != 16'h0000) |=> frame_drop && !cmd_valid ##1 tx_oe_n [*8];
	endproperty
	a_drop_silent: assert property (p_drop_silent) else $error("bad frame acted on");
	property p_cmd_addr;
		cmd_valid |-> cmd_bcast ? $past(s.rbuf[0]) == mrs_pkg::BCAST_ADDR : $past(s.rbuf[0]) == station_addr;
	endproperty
	a_cmd_addr: assert property (p_cmd_addr) else $error("command for foreign address");
endmodule : mrs_framer
`default_nettype wire

//--- logic/mrs_pkg.sv
package mrs_pkg;
	// ----------------------------------------
	// clock and line timing
	// ----------------------------------------
	localparam int CLK_HZ = 10000000;
	localparam int BAUD_2400 = 2400;
	localparam int BAUD_4800 = 4800;
	localparam int BAUD_9600 = 9600;
	localparam int BAUD_19200 = 19200;
	localparam int BAUD_38400 = 38400;
	localparam logic [2:0] SEL_2400 = 3'h0;
	localparam logic [2:0] SEL_4800 = 3'h1;
	localparam logic [2:0] SEL_9600 = 3'h2;
	localparam logic [2:0] SEL_19200 = 3'h3;
	localparam logic [2:0] SEL_38400 = 3'h4;
	localparam int CHAR_BITS = 11;
	// silent intervals in tenths of a character time
	localparam int GAP15_X10 = 15;
	localparam int GAP35_X10 = 35;
	localparam logic [6:0] GAP15_HALF = 7'(CHAR_BITS * 2 * GAP15_X10 / 10);
	localparam logic [6:0] GAP35_HALF = 7'(CHAR_BITS * 2 * GAP35_X10 / 10);
	localparam logic [3:0] TX_FRAME_BITS = 4'(CHAR_BITS);

	// ----------------------------------------
	// frame contents
	// ----------------------------------------
	localparam logic [7:0] BCAST_ADDR = 8'h00;
	localparam logic [7:0] MAX_ADDR = 8'hf7;
	localparam logic [7:0] FC_READ_HOLD = 8'h03;
	localparam logic [7:0] FC_WRITE_ONE = 8'h06;
	localparam logic [7:0] FC_WRITE_MANY = 8'h10;
	localparam logic [7:0] EXC_FLAG = 8'h80;
	localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
	localparam logic [7:0] MAX_RSP_DATA = 8'hfa;
	localparam logic [7:0] MIN_FRAME = 8'h04;
	localparam logic [7:0] HDR_BYTES = 8'h02;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'ha001;

	typedef enum logic [2:0] {
		RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h3, RX_PAR = 3'h2, RX_STOP = 3'h6
	} mrs_rx_st_t;
	typedef enum logic [2:0] {
		FR_HUNT = 3'h0, FR_RECV = 3'h1, FR_CHECK = 3'h3, FR_WAIT = 3'h2, FR_SEND = 3'h6
	} mrs_fr_st_t;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// half a bit period in clocks; unknown codes fall back to 9600
	function automatic logic [11:0] mrs_half_div(input logic [2:0] sel);
		int rate;
		unique case (sel)
			SEL_2400: rate = BAUD_2400;
			SEL_4800: rate = BAUD_4800;
			SEL_19200: rate = BAUD_19200;
			SEL_38400: rate = BAUD_38400;
			default: rate = BAUD_9600;
		endcase
		return 12'(CLK_HZ / (2 * rate));
	endfunction : mrs_half_div

	function automatic logic mrs_par(input logic [7:0] d, input logic odd);
		return (^d) ^ odd;
	endfunction : mrs_par

	function automatic logic [15:0] mrs_crc_byte(input logic [15:0] crc, input logic [7:0] b);
		logic [15:0] c;
		c = crc ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction : mrs_crc_byte
endpackage : mrs_pkg

//--- logic/mrs_uart_rx.sv
`timescale 1ns/1ps
`default_nettype none
module mrs_uart_rx (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic rx_in,
	input wire logic [11:0] half_div,
	input wire logic parity_en,
	input wire logic parity_odd,
	output logic byte_valid,
	output logic [7:0] byte_data,
	output logic byte_perr,
	output logic gap15,
	output logic gap35
);
	typedef struct packed {
		mrs_pkg::mrs_rx_st_t st;
		logic [11:0] div;
		logic ph;
		logic [2:0] idx;
		logic [7:0] sh;
		logic perr;
		logic [6:0] gap;
		logic byte_valid;
		logic [7:0] byte_data;
		logic byte_perr;
		logic gap15;
		logic gap35;
	} mrs_rx_t;

	mrs_rx_t s;
	mrs_rx_t next_s;
	logic tick;

	assign tick = (s.div == 12'(half_div - 12'h001));

	// ----------------------------------------
	// receiver, always listening
	// ----------------------------------------
	always_comb begin
		next_s = s;
		next_s.byte_valid = 1'b0;
		next_s.div = tick ? 12'h000 : 12'(s.div + 12'h001);
		next_s.gap15 = (s.gap >= mrs_pkg::GAP15_HALF);
		next_s.gap35 = (s.gap >= mrs_pkg::GAP35_HALF);
		if (tick) begin
			next_s.ph = ~s.ph;
		end
		unique case (s.st)
			mrs_pkg::RX_IDLE: begin
				// silence measured in half bits from the mid stop sample
				if (tick && s.gap != mrs_pkg::GAP35_HALF) begin
					next_s.gap = 7'(s.gap + 7'h01);
				end
				if (!rx_in) begin
					next_s.st = mrs_pkg::RX_START;
					next_s.div = 12'h000;
					next_s.gap = 7'h00;
				end
			end
			mrs_pkg::RX_START: if (tick) begin
				next_s.st = rx_in ? mrs_pkg::RX_IDLE : mrs_pkg::RX_DATA;
				next_s.ph = 1'b0;
				next_s.idx = 3'h0;
			end
			mrs_pkg::RX_DATA: if (tick && s.ph) begin
				next_s.sh = {rx_in, s.sh[7:1]};
				next_s.idx = 3'(s.idx + 3'h1);
				if (s.idx == 3'h7) begin
					next_s.st = parity_en ? mrs_pkg::RX_PAR : mrs_pkg::RX_STOP;
				end
			end
			mrs_pkg::RX_PAR: if (tick && s.ph) begin
				next_s.perr = rx_in ^ mrs_pkg::mrs_par(s.sh, parity_odd);
				next_s.st = mrs_pkg::RX_STOP;
			end
			mrs_pkg::RX_STOP: if (tick && s.ph) begin
				next_s.byte_valid = 1'b1;
				next_s.byte_data = s.sh;
				next_s.byte_perr = s.perr | ~rx_in;
				next_s.perr = 1'b0;
				next_s.st = mrs_pkg::RX_IDLE;
			end
			default: next_s.st = mrs_pkg::RX_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign byte_valid = s.byte_valid;
	assign byte_data = s.byte_data;
	assign byte_perr = s.byte_perr;
	assign gap15 = s.gap15;
	assign gap35 = s.gap35;

	property p_gap_order;
		@(posedge sys_clk) disable iff (rst) s.gap35 |-> s.gap15;
	endproperty
	a_gap_order: assert property (p_gap_order) else $error("long gap without short gap");
endmodule : mrs_uart_rx
`default_nettype wire

//--- verification/mrs_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module mrs_master_model (
	input wire logic sys_clk,
	input wire logic line,
	input wire logic parity_en,
	input wire logic parity_odd,
	input wire logic [11:0] half_div,
	output logic drive_out
);
	// released pair idles high through the bus bias
	initial drive_out = 1'h1;

	// ----------------------------------------
	// character and check value
	// ----------------------------------------
	function automatic logic [10:0] char_frame(input logic [7:0] b);
		if (parity_en) begin
			return {1'h1, (^b) ^ parity_odd, b, 1'h0};
		end
		return {2'h3, b, 1'h0};
	endfunction : char_frame

	function automatic logic [15:0] crc16(input logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (q[i]) begin
			c = c ^ {8'h00, q[i]};
			for (int k = 0; k < 8; k++) begin
				c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
			end
		end
		return c;
	endfunction : crc16

	// ----------------------------------------
	// query out, reply in
	// ----------------------------------------
	// binary frame only; spoil flips bit 0 of the check value; quiet is the lead-in silence in half bits
	task automatic send_frame(input logic [7:0] q[$], input logic spoil, input int quiet);
		logic [15:0] c;
		logic [10:0] f;
		c = crc16(q) ^ {15'h0000, spoil};
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		repeat (quiet * half_div) @(negedge sys_clk);
		foreach (q[i]) begin
			f = char_frame(q[i]);
			for (int n = 0; n < 11; n++) begin
				drive_out = f[n];
				repeat (2 * half_div) @(negedge sys_clk);
			end
		end
	endtask : send_frame

	// a start edge missing within limit leaves the idle pattern
	task automatic recv_char(output logic [10:0] f, input int limit);
		int w;
		f = 11'h7ff;
		w = 0;
		while (line !== 1'b0 && w < limit) begin
			@(negedge sys_clk);
			w++;
		end
		if (line !== 1'b0) return;
		repeat (half_div) @(negedge sys_clk);
		for (int n = 0; n < 11; n++) begin
			f[n] = line;
			if (n < 10) repeat (2 * half_div) @(negedge sys_clk);
		end
	endtask : recv_char
endmodule : mrs_master_model
`default_nettype wire

//--- verification/mrs_framer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module mrs_framer_bench;
	// ----------------------------------------
	// wiring
	// ----------------------------------------
	// floor(10 MHz / (2 * 38400))
	localparam logic [11:0] HALF = 12'h082;
	localparam int LIMIT = 300000;
	logic sys_clk, rst, rx_line, tx_out, tx_oe_n, master_out;
	logic parity_en, parity_odd, cmd_valid, cmd_bcast, rsp_valid, frame_drop;
	logic [2:0] baud_sel;
	logic [7:0] station_addr, cmd_func, cmd_len, app_idx, app_data, rsp_exc, rsp_len, rsp_byte, rsp_idx;
	logic [7:0] rsp_mem[4];
	logic [7:0] q[$];
	logic [7:0] e[$];
	int n_mismatch, checks, cycles, n_cmd, n_drop, n_tx;

	assign rx_line = tx_oe_n ? master_out : tx_out;
	assign rsp_byte = rsp_mem[rsp_idx[1:0]];

	mrs_framer i_mrs_framer (.sys_clk(sys_clk), .rst(rst), .rx_in(rx_line), .tx_out(tx_out),
		.tx_oe_n(tx_oe_n), .baud_sel(baud_sel), .parity_en(parity_en), .parity_odd(parity_odd),
		.station_addr(station_addr), .cmd_valid(cmd_valid), .cmd_func(cmd_func), .cmd_bcast(cmd_bcast),
		.cmd_len(cmd_len), .app_idx(app_idx), .app_data(app_data), .rsp_valid(rsp_valid),
		.rsp_exc(rsp_exc), .rsp_len(rsp_len), .rsp_byte(rsp_byte), .rsp_idx(rsp_idx),
		.frame_drop(frame_drop));

	mrs_master_model i_mrs_master_model (.sys_clk(sys_clk), .line(rx_line), .parity_en(parity_en),
		.parity_odd(parity_odd), .half_div(HALF), .drive_out(master_out));

	initial begin
		sys_clk = 1'h0;
		forever #50 sys_clk = ~sys_clk;
	end

	// counted mid cycle so that one-cycle pulses are seen settled
	always @(negedge sys_clk) begin
		cycles++;
		if (cmd_valid === 1'b1) n_cmd++;
		if (frame_drop === 1'b1) n_drop++;
		if (tx_oe_n === 1'b0) n_tx++;
		if (cycles == LIMIT) begin
			n_mismatch++;
			stop_test();
		end
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : stop_test

	task automatic respond(input logic [7:0] exc, input logic [7:0] len);
		rsp_exc = exc;
		rsp_len = len;
		rsp_valid = 1'h1;
		@(negedge sys_clk);
		rsp_valid = 1'h0;
	endtask : respond

	task automatic reply(input logic [7:0] r[$], input int first);
		logic [15:0] c;
		logic [10:0] f;
		int lim;
		c = i_mrs_master_model.crc16(r);
		r.push_back(c[7:0]);
		r.push_back(c[15:8]);
		lim = first;
		foreach (r[i]) begin
			i_mrs_master_model.recv_char(f, lim);
			check({5'h00, f}, {5'h00, i_mrs_master_model.char_frame(r[i])});
			check({15'h0000, tx_oe_n}, 16'h0000);
			lim = 3 * HALF;
		end
		repeat (3 * HALF) @(negedge sys_clk);
		check({14'h0000, tx_oe_n, tx_out}, 16'h0003);
	endtask : reply

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		int b, d, c;
		rst = 1'h1;
		baud_sel = mrs_pkg::SEL_38400;
		parity_en = 1'h1;
		parity_odd = 1'h0;
		station_addr = 8'h01;
		app_idx = 8'h00;
		rsp_valid = 1'h0;
		rsp_exc = 8'h00;
		rsp_len = 8'h00;
		rsp_mem = '{8'h00, 8'h00, 8'h00, 8'h00};
		void'($urandom(88));
		repeat (12) @(negedge sys_clk);
		rst = 1'h0;

		// read query to own address, normal reply
		parity_odd = 1'($urandom);
		station_addr = 8'(1 + $urandom % 247);
		q = {station_addr, 8'h03, 8'($urandom), 8'($urandom), 8'h00, 8'h01};
		b = n_cmd;
		i_mrs_master_model.send_frame(q, 1'h0, 80);
		repeat (80 * HALF) @(negedge sys_clk);
		check(16'(n_cmd - b), 16'h0001);
		check({8'h00, cmd_func}, 16'h0003);
		check({15'h0000, cmd_bcast}, 16'h0000);
		check({8'h00, cmd_len}, 16'h0004);
		for (int k = 0; k < 4; k++) begin
			app_idx = 8'(k);
			@(negedge sys_clk);
			check({8'h00, app_data}, {8'h00, q[k + 2]});
		end
		rsp_mem = '{8'h02, 8'($urandom), 8'($urandom), 8'h00};
		respond(8'h00, 8'h03);
		e = {station_addr, 8'h03, rsp_mem[0], rsp_mem[1], rsp_mem[2]};
		reply(e, 4 * HALF);
		$display("test 1 done, mismatches %0d", n_mismatch);

		// noise cut off by a short gap, then broadcast write: executed, never answered
		q = {8'($urandom), 8'($urandom)};
		i_mrs_master_model.send_frame(q, 1'h0, 80);
		q = {8'h00, 8'h10};
		b = n_cmd;
		d = n_drop;
		// gap between 1.5 and 3.5 characters: the noise must be flushed, not merged
		i_mrs_master_model.send_frame(q, 1'h0, 50);
		repeat (80 * HALF) @(negedge sys_clk);
		check(16'(n_cmd - b), 16'h0001);
		check(16'(n_drop - d), 16'h0000);
		check({7'h00, cmd_bcast, cmd_func}, 16'h0110);
		check({8'h00, cmd_len}, 16'h0000);
		b = n_tx;
		respond(8'h00, 8'h00);
		repeat (40 * HALF) @(negedge sys_clk);
		check(16'(n_tx - b), 16'h0000);
		$display("test 2 done, mismatches %0d", n_mismatch);

		// unsupported function, two stop bits: exception reply
		parity_en = 1'h0;
		q = {station_addr, 8'h2b};
		b = n_cmd;
		// line already quiet since the broadcast frame
		i_mrs_master_model.send_frame(q, 1'h0, 8);
		e = {station_addr, 8'hab, 8'h01};
		reply(e, 90 * HALF);
		check(16'(n_cmd - b), 16'h0000);
		$display("test 3 done, mismatches %0d", n_mismatch);

		// spoiled check value: dropped, no reply
		parity_en = 1'h1;
		q = {station_addr, 8'h06, 8'h00, 8'h01, 8'($urandom), 8'($urandom)};
		b = n_tx;
		d = n_drop;
		c = n_cmd;
		i_mrs_master_model.send_frame(q, 1'h1, 80);
		repeat (80 * HALF) @(negedge sys_clk);
		check(16'(n_drop - d), 16'h0001);
		check(16'(n_cmd - c), 16'h0000);
		check(16'(n_tx - b), 16'h0000);
		$display("test 4 done, mismatches %0d", n_mismatch);
		stop_test();
	end
endmodule : mrs_framer_bench
`default_nettype wire
